// ### core/gate_cfg_pkg.sv
// constants, field layouts and types for the gate driver config bank
// assumes a 125 MHz core clock and an 8-bit addressed 16-bit register port, one address per register
package gate_cfg_pkg;
  // register addresses
  localparam logic [7:0] ADDR_DEAD_TIME = 8'h1B;
  localparam logic [7:0] ADDR_PUMP = 8'h1C;
  localparam logic [7:0] ADDR_SENSE = 8'h1D;
  // reset values
  localparam logic [15:0] RST_DEAD_TIME = 16'h3131;
  localparam logic [15:0] RST_PUMP = 16'h0000;
  localparam logic [15:0] RST_SENSE = 16'h0028;
  localparam logic [15:0] PUMP_RW_MASK = 16'h0007;
  // field positions
  localparam int RISE_LSB = 0;
  localparam int FALL_LSB = 8;
  localparam int PUMP_FREQ_LSB = 0;
  localparam int PUMP_SPREAD_BIT = 2;
  localparam int GAIN_LSB = 0;
  localparam int GAIN_PIN_BIT = 3;
  localparam int ENABLE_LSB = 4;
  localparam int BLANK_LSB = 7;
  localparam int DCCAL_BIT = 11;
  localparam int DEGLITCH_LSB = 12;
  localparam int TRIGGER_LSB = 14;
  // timing
  localparam int CLK_MHZ = 125;
  localparam int DT_BASE_NS = 120;
  localparam int DT_STEP_NS = 80;
  localparam int DT_MAX_NS = 12040;
  localparam logic [7:0] DT_MAX_CODE = 8'h95;
  localparam int DT_MAX_CYC = (DT_MAX_NS * CLK_MHZ + 999) / 1000;
  localparam int DEGLITCH_8US_CYC = 8 * CLK_MHZ;
  localparam int CNT_W = 11;
  localparam logic [4:0] FAULT_COUNT_8 = 5'h08;
  localparam logic [4:0] FAULT_COUNT_16 = 5'h10;
  // charge pump half-period counts at 125 MHz, code 00..11
  localparam int PUMP_HALF_00 = 80;
  localparam int PUMP_HALF_01 = 160;
  localparam int PUMP_HALF_10 = 320;
  localparam int PUMP_HALF_11 = 40;
  // bus request carrier
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } reg_req_s;
  // fault trigger codes
  typedef enum logic [1:0] {
    TRIG_COUNT8 = 2'h0,
    TRIG_COUNT16 = 2'h1,
    TRIG_EVERY = 2'h2,
    TRIG_NONE = 2'h3
  } trigger_e;
  // overcurrent deglitch state, one-hot
  typedef enum logic [2:0] {
    OC_IDLE = 3'h1,
    OC_WAIT = 3'h2,
    OC_HELD = 3'h4
  } oc_state_e;
endpackage : gate_cfg_pkg

// ### core/gate_cfg_bank.sv
// config bank: dead time, charge pump clock, current sense setup
// assumes the register port is synchronous to clk from an SPI front end
// Behaviour
// [RULE1] rise dead time 120ns plus 80ns per code
// [RULE2] fall dead time same coding, upper byte
// [RULE3] pump clock frequency from two-bit code
// [RULE4] spread spectrum on unless bit two set
// [RULE5] pump register upper bits read zero
// [RULE6] digital gain codes map 4 to 64
// [RULE7] pin resistor gain overrides register gain
// [RULE8] per-phase amplifier enable bits
// [RULE9] blanking time from four-bit code
// [RULE10] dc calibration holds stages high impedance
// [RULE11] overcurrent deglitch 0,2,4,8 us
// [RULE12] deglitch bypassed when truncation enabled
// [RULE13] fault after 8, 16 or every event
// [RULE14] code three never faults, truncation continues
// [RULE15] truncation unless disabled, fault unaffected
// [RULE16] dead time between complementary switch turn-on
module gate_cfg_bank
  import gate_cfg_pkg::*;
(
  input wire logic clk, // 125 MHz core clock
  input wire logic arst_n, // async reset, active low
  input wire reg_req_s req, // register request, one cycle
  output logic [15:0] rdata, // read data, valid cycle after rd
  input wire logic trunc_disable, // truncation disable from second reg
  input wire logic [2:0] pwm_high, // per-phase high-side command
  input wire logic overcurrent_raw, // amplifier comparator, async
  output logic [2:0] gate_high, // high-side gate enables
  output logic [2:0] gate_low, // low-side gate enables
  output logic pump_clk, // charge pump switching clock
  output logic pump_spread_on, // spread spectrum active
  output logic [6:0] sense_gain, // applied gain in V/V
  output logic sense_gain_pin, // gain taken from pin resistor
  output logic [2:0] sense_enable, // amplifier enables A,B,C
  output logic [13:0] sense_blank_ns, // blanking time in ns
  output logic dccal_active, // calibration mode running
  output logic pwm_truncate, // truncate current pulse
  output logic overcurrent_fault // overcurrent fault level
);

  logic [15:0] dead_time_config;
  logic [15:0] charge_pump_config;
  logic [15:0] current_sense_config;

  // dead time code to cycles; unused codes fall back to code zero
  function automatic logic [CNT_W-1:0] dt_cycles(input logic [7:0] code);
    int ns;
    ns = (code > DT_MAX_CODE) ? DT_BASE_NS :
         DT_BASE_NS + DT_STEP_NS * int'(code);
    return CNT_W'((ns * CLK_MHZ + 999) / 1000);
  endfunction : dt_cycles

  // address decode
  wire hit_dt = (req.addr == ADDR_DEAD_TIME);
  wire hit_cp = (req.addr == ADDR_PUMP);
  wire hit_cs = (req.addr == ADDR_SENSE);

  // register writes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dead_time_config <= RST_DEAD_TIME;
      charge_pump_config <= RST_PUMP;
      current_sense_config <= RST_SENSE;
    end else if (req.wr) begin
      if (hit_dt) dead_time_config <= req.wdata;
      if (hit_cp) charge_pump_config <= req.wdata & PUMP_RW_MASK; // [RULE5]
      if (hit_cs) current_sense_config <= req.wdata;
    end
  end

  // read mux, unmapped reads zero
  wire [15:0] next_rdata = !req.rd ? rdata :
                           hit_dt ? dead_time_config :
                           hit_cp ? (charge_pump_config & PUMP_RW_MASK) :
                           hit_cs ? current_sense_config : 16'h0000;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) rdata <= 16'h0000;
    else rdata <= next_rdata;
  end

  // field extraction
  wire [7:0] rise_code = dead_time_config[RISE_LSB+:8];
  wire [7:0] fall_code = dead_time_config[FALL_LSB+:8];
  wire [1:0] freq_code = charge_pump_config[PUMP_FREQ_LSB+:2];
  wire spread_off = charge_pump_config[PUMP_SPREAD_BIT];
  wire [2:0] gain_code = current_sense_config[GAIN_LSB+:3];
  wire gain_pin = current_sense_config[GAIN_PIN_BIT];
  wire [2:0] enables = current_sense_config[ENABLE_LSB+:3];
  wire [3:0] blank_code = current_sense_config[BLANK_LSB+:4];
  wire dccal = current_sense_config[DCCAL_BIT];
  wire [1:0] deglitch_code = current_sense_config[DEGLITCH_LSB+:2];
  wire [1:0] trig_raw = current_sense_config[TRIGGER_LSB+:2];
  wire trigger_e trig = trigger_e'(trig_raw);

  wire [CNT_W-1:0] rise_cyc = dt_cycles(rise_code); // [RULE1]
  wire [CNT_W-1:0] fall_cyc = dt_cycles(fall_code); // [RULE2]

  // gain table, pin resistor gain reported as zero code
  wire [6:0] reg_gain = (gain_code == 3'h6) ? 7'h20 :
                        (gain_code == 3'h7) ? 7'h40 :
                        7'({gain_code, 2'h0} + 5'h04); // [RULE6]
  wire [6:0] next_gain = gain_pin ? 7'h00 : reg_gain; // [RULE7]

  // blanking table in ns
  wire [13:0] next_blank = (blank_code == 4'h0) ? 14'h0000 :
    (blank_code == 4'h1) ? 14'h0032 :
    (blank_code <= 4'hA) ? 14'(100 * (int'(blank_code) - 1)) :
    (blank_code == 4'hB) ? 14'h03E8 :
    (blank_code == 4'hC) ? 14'h07D0 :
    (blank_code == 4'hD) ? 14'h0FA0 :
    (blank_code == 4'hE) ? 14'h1770 : 14'h1F40; // [RULE9]

  // static config outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pump_spread_on <= 1'b0;
      sense_gain <= 7'h00;
      sense_gain_pin <= 1'b0;
      sense_enable <= 3'h0;
      sense_blank_ns <= 14'h0000;
      dccal_active <= 1'b0;
    end else begin
      pump_spread_on <= !spread_off; // [RULE4]
      sense_gain <= next_gain;
      sense_gain_pin <= gain_pin; // [RULE7]
      sense_enable <= enables; // [RULE8]
      sense_blank_ns <= next_blank;
      dccal_active <= dccal; // [RULE10]
    end
  end

  // charge pump clock divider with simple dither for spread spectrum
  wire [8:0] half_period = (freq_code == 2'h0) ? 9'(PUMP_HALF_00) :
                           (freq_code == 2'h1) ? 9'(PUMP_HALF_01) :
                           (freq_code == 2'h2) ? 9'(PUMP_HALF_10) :
                           9'(PUMP_HALF_11); // [RULE3]
  logic [8:0] pump_cnt;
  logic [3:0] dither;
  wire [8:0] pump_limit = spread_off ? half_period :
                          half_period + 9'({5'h00, dither}) - 9'h008; // [RULE4]
  wire pump_wrap = (pump_cnt >= pump_limit - 9'h001);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pump_cnt <= 9'h000;
      pump_clk <= 1'b0;
      dither <= 4'h0;
    end else if (pump_wrap) begin
      pump_cnt <= 9'h000;
      pump_clk <= !pump_clk;
      dither <= dither + 4'h5;
    end else begin
      pump_cnt <= pump_cnt + 9'h001;
    end
  end

  // pwm command synchroniser, the pins run asynchronous to clk
  logic [2:0] pwm_meta;
  logic [2:0] pwm_sync;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwm_meta <= 3'h0;
      pwm_sync <= 3'h0;
    end else begin
      pwm_meta <= pwm_high;
      pwm_sync <= pwm_meta;
    end
  end

  // dead time insertion per phase: low off, wait, high on and back
  logic [2:0] [CNT_W-1:0] dt_cnt;
  genvar p;
  for (p = 0; p < 3; p++) begin : g_phase
    wire want_high = pwm_sync[p] && !dccal && !pwm_truncate;
    wire want_low = !pwm_sync[p] && !dccal;
    wire busy = (dt_cnt[p] != '0);
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        gate_high[p] <= 1'b0;
        gate_low[p] <= 1'b0;
        dt_cnt[p] <= '0;
      end else if (dccal) begin
        gate_high[p] <= 1'b0; // [RULE10]
        gate_low[p] <= 1'b0;
        dt_cnt[p] <= '0;
      end else if (want_high && gate_low[p]) begin
        gate_low[p] <= 1'b0;
        dt_cnt[p] <= rise_cyc; // [RULE16]
      end else if (want_low && gate_high[p]) begin
        gate_high[p] <= 1'b0;
        dt_cnt[p] <= fall_cyc; // [RULE16]
      end else if (busy) begin
        dt_cnt[p] <= dt_cnt[p] - CNT_W'(1);
      end else begin
        gate_high[p] <= want_high;
        gate_low[p] <= want_low && !gate_high[p];
      end
    end
  end

  // overcurrent input synchroniser
  logic oc_meta;
  logic oc_sync;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      oc_meta <= 1'b0;
      oc_sync <= 1'b0;
    end else begin
      oc_meta <= overcurrent_raw;
      oc_sync <= oc_meta;
    end
  end

  // deglitch length, bypassed while truncation is enabled
  wire [CNT_W-1:0] deglitch_cyc =
    (deglitch_code == 2'h0) ? CNT_W'(0) :
    (deglitch_code == 2'h1) ? CNT_W'(DEGLITCH_8US_CYC / 4) :
    (deglitch_code == 2'h2) ? CNT_W'(DEGLITCH_8US_CYC / 2) :
    CNT_W'(DEGLITCH_8US_CYC); // [RULE11]
  wire bypass = !trunc_disable || (deglitch_cyc == '0); // [RULE12]

  oc_state_e oc_state;
  logic [CNT_W-1:0] oc_cnt;
  wire oc_event = (oc_state != OC_HELD) && oc_sync &&
                  (bypass || (oc_state == OC_WAIT && oc_cnt == CNT_W'(1)));
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      oc_state <= OC_IDLE;
      oc_cnt <= '0;
    end else begin
      case (oc_state)
        OC_IDLE: begin
          if (oc_sync && bypass) oc_state <= OC_HELD;
          else if (oc_sync) begin
            oc_state <= OC_WAIT;
            oc_cnt <= deglitch_cyc;
          end
        end
        OC_WAIT: begin
          if (!oc_sync) oc_state <= OC_IDLE;
          else if (oc_event) oc_state <= OC_HELD;
          else oc_cnt <= oc_cnt - CNT_W'(1);
        end
        OC_HELD: if (!oc_sync) oc_state <= OC_IDLE;
        default: oc_state <= OC_IDLE;
      endcase
    end
  end

  // event counting into fault, truncation independent of fault
  logic [4:0] ev_cnt;
  wire [4:0] ev_next = ev_cnt + 5'h01;
  wire fault_hit = oc_event && (
    (trig == TRIG_EVERY) ||
    (trig == TRIG_COUNT8 && ev_next >= FAULT_COUNT_8) ||
    (trig == TRIG_COUNT16 && ev_next >= FAULT_COUNT_16)); // [RULE13] [RULE14]
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ev_cnt <= 5'h00;
      overcurrent_fault <= 1'b0;
      pwm_truncate <= 1'b0;
    end else begin
      if (fault_hit) ev_cnt <= 5'h00;
      else if (oc_event) ev_cnt <= ev_next;
      overcurrent_fault <= fault_hit || (overcurrent_fault && oc_sync);
      pwm_truncate <= !trunc_disable && oc_sync; // [RULE15] [RULE14]
    end
  end

endmodule : gate_cfg_bank

// ### sim/gate_cfg_bank_properties.sv
// port assertions for the config bank
// assumes a bind from tb and one clock domain
module gate_cfg_bank_properties
  import gate_cfg_pkg::*;
(
  input wire logic clk, // clock
  input wire logic arst_n, // reset
  input wire reg_req_s req, // request
  input wire logic [15:0] rdata, // read data
  input wire logic trunc_disable, // no truncate
  input wire logic [2:0] gate_high, // high gates
  input wire logic [2:0] gate_low, // low gates
  input wire logic pump_spread_on, // spread on
  input wire logic [6:0] sense_gain, // gain
  input wire logic sense_gain_pin, // pin gain
  input wire logic [2:0] sense_enable, // enables
  input wire logic dccal_active, // calibration
  input wire logic pwm_truncate // truncate
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // config outputs follow writes two edges later
  a_spread_map: assert property (
    req.wr && req.addr == ADDR_PUMP |->
    ##2 pump_spread_on == !$past(req.wdata[2], 2)) else $error("spread");
  a_enable_map: assert property (
    req.wr && req.addr == ADDR_SENSE |->
    ##2 sense_enable == $past(req.wdata[6:4], 2)) else $error("enable");
  a_pump_upper: assert property (
    req.rd && req.addr == ADDR_PUMP |=> rdata[15:3] == 13'h0000)
    else $error("pump upper");
  a_pin_gain: assert property (
    sense_gain_pin |-> sense_gain == 7'h00) else $error("pin gain");
  a_gain_set: assert property (
    sense_gain != 7'h00 |-> sense_gain inside {7'h04, 7'h08, 7'h0C,
    7'h10, 7'h14, 7'h18, 7'h20, 7'h40}) else $error("gain value");
  a_no_shoot: assert property (
    (gate_high & gate_low) == 3'h0) else $error("shoot through");
  a_trunc_off: assert property (
    $past(trunc_disable) |-> !pwm_truncate) else $error("truncate");
  a_dccal_off: assert property (
    dccal_active && $past(dccal_active) |-> (gate_high | gate_low) == 3'h0)
    else $error("dccal gates");
endmodule : gate_cfg_bank_properties

// ### sim/host_model.sv
// host side of the register port
// assumes the bank samples req on rising clk
module host_model
  import gate_cfg_pkg::*;
(
  input wire logic clk, // clock
  input wire logic [15:0] rdata, // read data
  output reg_req_s req // request
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '{1'b0, 1'b0, 8'h00, 16'h0000};
  // one request cycle, then the idle bus is scrambled
  task automatic send(input logic w, input logic [7:0] a,
                      input logic [15:0] d);
    @(posedge clk);
    req <= '{w, !w, a, d};
    @(posedge clk);
    req <= '{1'b0, 1'b0, ~a, ~d};
  endtask : send
  task automatic read(input logic [7:0] a, output logic [15:0] d);
    send(1'b0, a, 16'h0000);
    @(posedge clk);
    d = rdata;
  endtask : read
endmodule : host_model

// ### sim/tb.sv
// self-checking bench for the config bank
// assumes package, bank, checker and host model compiled first
module tb
  import gate_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, arst_n = 1'b0, trunc_disable = 1'b0;
  logic overcurrent_raw = 1'b0, pump_clk, pump_spread_on;
  logic sense_gain_pin, dccal_active, pwm_truncate, overcurrent_fault;
  logic [2:0] pwm_high = 3'h0, gate_high, gate_low, sense_enable;
  logic [6:0] sense_gain;
  logic [13:0] sense_blank_ns;
  logic [15:0] rdata, s;
  reg_req_s req;
  int n_mismatch = 0, total_checks = 0, cycles = 0, trig, np, e_flt;
  // pump half periods in cycles: 125 MHz over twice the pump rate
  int half_tab [4] = '{80, 160, 320, 40};
  int model [3];
  int gain_tab [8] = '{4, 8, 12, 16, 20, 24, 32, 64};
  int blank_tab [16] = '{0, 50, 100, 200, 300, 400, 500, 600, 700, 800,
                         900, 1000, 2000, 4000, 6000, 8000};
  int dt_tab [3] = '{16'h9501, 16'hFF95, 16'h0096};
  // last entry: truncation disabled, 2 us deglitch, fault on every event
  int oc_tab [5] = '{16'h3000, 16'h4000, 16'hB000, 16'hC000, 16'h9000};
  gate_cfg_bank i_gate_cfg_bank (.clk, .arst_n, .req, .rdata,
    .trunc_disable, .pwm_high, .overcurrent_raw, .gate_high, .gate_low,
    .pump_clk, .pump_spread_on, .sense_gain, .sense_gain_pin,
    .sense_enable, .sense_blank_ns, .dccal_active, .pwm_truncate,
    .overcurrent_fault);
  host_model u_host (.clk, .rdata, .req);
  initial begin
    forever #4 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  task automatic do_reset();
    arst_n <= 1'b0;
    model = '{16'h3131, 16'h0000, 16'h0028};
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
  endtask : do_reset
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    u_host.send(1'b1, a, d);
    if (a inside {[8'h1B:8'h1D]}) begin
      model[a - 8'h1B] = (a == ADDR_PUMP) ? d & 16'h0007 : d;
    end
  endtask : wr
  task automatic chk_rd(input logic [7:0] a);
    logic [15:0] d;
    u_host.read(a, d);
    cmp(d, a inside {[8'h1B:8'h1D]} ? 16'(model[a - 8'h1B]) : 16'h0000);
  endtask : chk_rd
  task automatic chk_out();
    s = 16'(model[2]);
    repeat (3) @(posedge clk);
    cmp(16'(pump_spread_on), 16'(!model[1][2]));
    cmp(16'(sense_gain_pin), 16'(s[3]));
    cmp(16'(sense_gain), s[3] ? 16'h0000 : 16'(gain_tab[s[2:0]]));
    cmp(16'(sense_enable), 16'(s[6:4]));
    cmp(16'(sense_blank_ns), 16'(blank_tab[s[10:7]]));
    cmp(16'(dccal_active), 16'(s[11]));
  endtask : chk_out
  // count cycles with both gates of phase A off
  task automatic gap(input logic [2:0] v, input int c);
    int g, e;
    g = 0;
    e = ((c > 8'h95 ? 120 : 120 + 80 * c) + 7) / 8;
    pwm_high <= v;
    repeat (3000) begin
      @(posedge clk);
      if ((v[0] ? gate_high[0] : gate_low[0]) === 1'b1) break;
      if ((gate_high[0] | gate_low[0]) === 1'b0) g++;
    end
    cmp(16'(g >= e && g <= e + 2), 16'h0001);
  endtask : gap
  // half period of the pump clock in cycles, spread off
  task automatic pump_half(input int c);
    logic q;
    int n;
    wr(ADDR_PUMP, 16'(c) | 16'h0004);
    q = pump_clk;
    n = 0;
    repeat (400) begin
      @(posedge clk);
      if (pump_clk !== q) break;
    end
    q = pump_clk;
    repeat (400) begin
      @(posedge clk);
      n++;
      if (pump_clk !== q) break;
    end
    cmp(16'(n), 16'(half_tab[c]));
  endtask : pump_half
  initial begin
    void'($urandom(89));
    do_reset();
    for (int a = 8'h1A; a <= 8'h1F; a++) chk_rd(8'(a));
    $display("test reset values done");
    for (int i = 0; i < 24; i++) begin
      s = 8'h1B + 8'($urandom % 4);
      wr(s[7:0], 16'($urandom) & 16'hFFF8 | 16'(i % 8));
      chk_rd(s[7:0]);
      chk_out();
    end
    wr(ADDR_SENSE, 16'h0028);
    $display("test register fields done");
    foreach (dt_tab[k]) begin
      wr(ADDR_DEAD_TIME, 16'(dt_tab[k]));
      pwm_high <= 3'h0;
      repeat (1600) @(posedge clk);
      gap(3'h7, dt_tab[k] & 8'hFF);
      gap(3'h0, dt_tab[k] >> 8);
    end
    $display("test dead time done");
    for (int c = 0; c < 4; c++) pump_half(c);
    $display("test pump clock done");
    foreach (oc_tab[k]) begin
      do_reset();
      trunc_disable <= (k == 4);
      trig = oc_tab[k] >> 14;
      np = trig == 0 ? 8 : (trig == 1 ? 16 : 4);
      wr(ADDR_SENSE, 16'(oc_tab[k]) | 16'h0028);
      for (int p = 1; p <= np; p++) begin
        overcurrent_raw <= 1'b1;
        repeat (6) @(posedge clk);
        e_flt = k != 4 && (trig == 2 || trig != 3 && p == np);
        cmp(16'(overcurrent_fault), 16'(e_flt));
        cmp(16'(pwm_truncate), 16'(k != 4));
        if (k == 4) begin
          repeat (240) @(posedge clk);
          cmp(16'(overcurrent_fault), 16'h0000);
          repeat (14) @(posedge clk);
          cmp(16'(overcurrent_fault), 16'h0001);
        end
        overcurrent_raw <= 1'b0;
        repeat (6) @(posedge clk);
      end
    end
    $display("test overcurrent done");
    results();
  end
endmodule : tb

bind gate_cfg_bank gate_cfg_bank_properties chk (.clk, .arst_n, .req,
  .rdata, .trunc_disable, .gate_high, .gate_low, .pump_spread_on,
  .sense_gain, .sense_gain_pin, .sense_enable, .dccal_active,
  .pwm_truncate);
